// *** rtgc_cfg.svh ***
// Register offsets, field positions, reset values and timing counts of the gain-code block
`ifndef RTGC_CFG_SVH
`define RTGC_CFG_SVH
`define RTGC_OFF_RX_GAIN 8'h09
`define RTGC_OFF_TX_GAIN 8'h0a
`define RTGC_OFF_SRC_SEL 8'h0b
`define RTGC_OFF_TX_ROUTE 8'h0e
`define RTGC_OFF_CTRL 8'h20
`define RTGC_OFF_STATUS 8'h21
`define RTGC_BIT_SPI_EN 6
`define RTGC_BIT_SEL_TX 6
`define RTGC_BIT_SEL_RX 5
`define RTGC_BIT_SW_STROBE 3
`define RTGC_BIT_NIB_EN 2
`define RTGC_BIT_MAP3 1
`define RTGC_BIT_CONV_OUT 0
`define RTGC_BIT_CLK_INV 1
`define RTGC_BIT_CLK_DIS 0
`define RTGC_RX_GAIN_RST 6'h00
`define RTGC_TX_GAIN_RST 6'h00
`define RTGC_SRC_SEL_FD_RST 8'h04
`define RTGC_SRC_SEL_HD_RST 8'h20
`define RTGC_PCLK_HALF 4
`endif

// *** rtgc_ctl.sv ***
// Controller end: drives gain pins and register port of the device
`include "rtgc_cfg.svh"
module rtgc_ctl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Link to device
  rtgc_if.ctl lnk,
  // User side
  input wire logic full_duplex_i,
  input wire logic tx_quiet_n_i,
  input wire logic [5:0] rx_gain_i,
  input wire logic rx_gain_req_i,
  input wire logic [5:0] tx_gain_i,
  input wire logic tx_gain_req_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  output logic busy_o
);
  rtgc_pkg::rtgc_st_t st_q;
  logic [5:0] pin_q;
  logic fd_q, ph_q;
  logic [7:0] addr_q, wdata_q;
  logic we_q, re_q;
  logic [2:0] pc_s;
  logic pc_edge;

  // Port clock is a foreign-domain pin: sync then detect rising edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_s <= 3'h0;
    end else begin
      pc_s <= {pc_s[1:0], lnk.port_clock_out};
    end
  end
  // Edge taken past the synchroniser so the first flop is never read by logic
  assign pc_edge = pc_s[1] & ~pc_s[2];

  // Direct-port transmit switch: deselect, present, select
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= rtgc_pkg::RTGC_IDLE;
      pin_q <= 6'h00;
      we_q <= 1'b0;
      re_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
    end else begin
      we_q <= 1'b0;
      re_q <= 1'b0;
      unique case (st_q)
        rtgc_pkg::RTGC_IDLE: begin
          if (reg_we_i || reg_re_i) begin // Software paces its gain writes
            we_q <= reg_we_i;
            re_q <= reg_re_i & ~reg_we_i;
            addr_q <= reg_addr_i;
            wdata_q <= reg_wdata_i;
          end else if (tx_gain_req_i && !fd_q) begin
            we_q <= 1'b1;
            addr_q <= `RTGC_OFF_SRC_SEL;
            wdata_q <= 8'h00;
            st_q <= rtgc_pkg::RTGC_DESEL;
          end else if (rx_gain_req_i) begin
            pin_q <= rx_gain_i;
          end
        end
        rtgc_pkg::RTGC_DESEL: begin
          pin_q <= tx_gain_i;
          st_q <= rtgc_pkg::RTGC_PRESENT;
        end
        rtgc_pkg::RTGC_PRESENT: begin
          st_q <= rtgc_pkg::RTGC_SELECT;
        end
        rtgc_pkg::RTGC_SELECT: begin
          we_q <= 1'b1;
          addr_q <= `RTGC_OFF_SRC_SEL;
          wdata_q <= 8'h40;
          st_q <= rtgc_pkg::RTGC_IDLE;
        end
      endcase
    end
  end

  // Mode, phase held low (gain loads), and reply data
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fd_q <= 1'b0;
      ph_q <= 1'b0;
      reg_rdata_o <= 8'h00;
      busy_o <= 1'b0;
    end else begin
      fd_q <= full_duplex_i;
      ph_q <= 1'b0;
      reg_rdata_o <= lnk.spi_rdata;
      busy_o <= (st_q != rtgc_pkg::RTGC_IDLE) || pc_edge;
    end
  end

  assign lnk.full_duplex = fd_q;
  assign lnk.tx_nibble = pin_q;
  assign lnk.transmit_nibble_phase = ph_q;
  // Bit five gated by quiet so the shared pin stays low while sending
  assign lnk.shared_strobe_pin = fd_q ? 1'b0 : (pin_q[5] & tx_quiet_n_i);
  assign lnk.direct_gain_low = pin_q[4:0];
  assign lnk.transmit_quiet_n = tx_quiet_n_i;
  assign lnk.spi_addr = addr_q;
  assign lnk.spi_wdata = wdata_q;
  assign lnk.spi_we = we_q;
  assign lnk.spi_re = re_q;
endmodule // rtgc_ctl

// *** rtgc_dev.sv ***
// Device end: receive amplifier and transmit attenuator gain-code registers
`include "rtgc_cfg.svh"
module rtgc_dev #(
  parameter int PCLK_HALF = `RTGC_PCLK_HALF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Link to controller
  rtgc_if.dev lnk,
  // Gain outputs toward analog stages
  output logic [5:0] rx_code_o,
  output logic [2:0] rx_stage1_o,
  output logic [2:0] rx_stage2_o,
  output logic [2:0] rx_stage3_o,
  output logic [3:0] tx_conv_o,
  output logic [1:0] tx_amp_o,
  // Nibble data toward interpolation filter
  output logic [5:0] filt_nibble_o,
  output logic filt_valid_o
);
  logic [1:0] mode_s, strb_s, ph_s;
  logic [5:0] nib_s1, nib_s2;
  logic [4:0] dg_s1, dg_s2;
  logic fd;
  logic [5:0] rx_q, tx_q;
  logic rx_en_q, tx_en_q;
  logic [7:0] sel_q, route_q, ctrl_q;
  logic [7:0] sel_eff;
  logic sel_set_q, clk_on_q, clk_inv_q;
  logic [7:0] rdata_q;
  logic [$clog2(PCLK_HALF+1)-1:0] div_q;
  logic pclk_q, pclk_out_q, sample_edge;
  logic [5:0] direct_gain_port;
  logic [5:0] rx_eff;

  // Two-flop synchronisers on the mode, strobe, phase, nibble and direct-gain pins; register port is not synchronised; mode is a strap but still async
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_s <= 2'h0;
      strb_s <= 2'h0;
      ph_s <= 2'h0;
      nib_s1 <= 6'h00;
      nib_s2 <= 6'h00;
      dg_s1 <= 5'h00;
      dg_s2 <= 5'h00;
    end else begin
      mode_s <= {mode_s[0], lnk.full_duplex};
      strb_s <= {strb_s[0], lnk.shared_strobe_pin};
      ph_s <= {ph_s[0], lnk.transmit_nibble_phase};
      nib_s1 <= lnk.tx_nibble;
      nib_s2 <= nib_s1;
      dg_s1 <= lnk.direct_gain_low;
      dg_s2 <= dg_s1;
    end
  end
  assign fd = mode_s[1];
  // Shared pin is strobe in full-duplex and bit five of the direct port otherwise
  assign direct_gain_port = {strb_s[1], dg_s2};

  // Nibble-rate port clock made by a divider; edge pulse marks the sampling edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= '0;
      pclk_q <= 1'b0;
      clk_on_q <= 1'b0;
      clk_inv_q <= 1'b0;
    end else if (div_q == ($clog2(PCLK_HALF+1))'(PCLK_HALF - 1)) begin
      div_q <= '0;
      pclk_q <= ~pclk_q;
      // Enable and invert change only at a half-period boundary, so no runt levels
      clk_on_q <= fd && !ctrl_q[`RTGC_BIT_CLK_DIS];
      clk_inv_q <= ctrl_q[`RTGC_BIT_CLK_INV];
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  // Inverting the output flips the sampling edge too, since both ports use it
  assign sample_edge = (div_q == ($clog2(PCLK_HALF+1))'(PCLK_HALF - 1)) &&
    (pclk_q == clk_inv_q);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pclk_out_q <= 1'b0;
    end else begin
      pclk_out_q <= clk_on_q && (pclk_q ^ clk_inv_q);
    end
  end
  assign lnk.port_clock_out = pclk_out_q;

  // Receive gain register: SPI, nibble port or direct port
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_q <= `RTGC_RX_GAIN_RST;
      rx_en_q <= 1'b0;
    end else if (lnk.spi_we && lnk.spi_addr == `RTGC_OFF_RX_GAIN) begin
      rx_en_q <= lnk.spi_wdata[`RTGC_BIT_SPI_EN];
      if (lnk.spi_wdata[`RTGC_BIT_SPI_EN]) begin
        rx_q <= lnk.spi_wdata[5:0];
      end
    end else if (fd && sel_eff[`RTGC_BIT_NIB_EN] && sample_edge && !ph_s[1] &&
      (strb_s[1] || sel_eff[`RTGC_BIT_SW_STROBE])) begin
      rx_q <= nib_s2;
    end else if (sel_eff[`RTGC_BIT_SEL_RX] && !fd) begin
      rx_q <= direct_gain_port;
    end else if (sel_eff[`RTGC_BIT_SEL_RX] && fd) begin
      rx_q <= {1'b0, dg_s2};
    end
  end

  // Transmit gain register: SPI or direct port
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_q <= `RTGC_TX_GAIN_RST;
      tx_en_q <= 1'b0;
    end else if (lnk.spi_we && lnk.spi_addr == `RTGC_OFF_TX_GAIN) begin
      tx_en_q <= lnk.spi_wdata[`RTGC_BIT_SPI_EN];
      if (lnk.spi_wdata[`RTGC_BIT_SPI_EN]) begin
        tx_q <= lnk.spi_wdata[5:0];
      end
    end else if (sel_eff[`RTGC_BIT_SEL_TX]) begin
      tx_q <= fd ? {1'b0, dg_s2} : direct_gain_port;
    end
  end

  // Configuration registers; source-select default depends on mode strap
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_q <= `RTGC_SRC_SEL_HD_RST;
      sel_set_q <= 1'b0;
      route_q <= 8'h00;
      ctrl_q <= 8'h00;
    end else if (lnk.spi_we && lnk.spi_addr == `RTGC_OFF_SRC_SEL) begin
      sel_q <= lnk.spi_wdata;
      sel_set_q <= 1'b1;
    end else if (lnk.spi_we && lnk.spi_addr == `RTGC_OFF_TX_ROUTE) begin
      route_q <= lnk.spi_wdata;
    end else if (lnk.spi_we && lnk.spi_addr == `RTGC_OFF_CTRL) begin
      ctrl_q <= lnk.spi_wdata;
    end else if (lnk.spi_we && lnk.spi_addr == `RTGC_OFF_STATUS) begin
      sel_q <= sel_q;
    end
  end
  // Until software writes the select register its default follows the mode strap,
  // which a reset branch cannot read since the strap only arrives through the synchroniser
  assign sel_eff = sel_set_q ? sel_q :
    (fd ? `RTGC_SRC_SEL_FD_RST : `RTGC_SRC_SEL_HD_RST);

  // Read data one cycle after the strobe; code visible only while access enabled
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 8'h00;
    end else if (lnk.spi_re) begin
      unique case (lnk.spi_addr)
        `RTGC_OFF_RX_GAIN: rdata_q <= {1'b0, rx_en_q, rx_en_q ? rx_q : 6'h00};
        `RTGC_OFF_TX_GAIN: rdata_q <= {1'b0, tx_en_q, tx_en_q ? tx_q : 6'h00};
        `RTGC_OFF_SRC_SEL: rdata_q <= sel_eff;
        `RTGC_OFF_TX_ROUTE: rdata_q <= route_q;
        `RTGC_OFF_CTRL: rdata_q <= ctrl_q;
        `RTGC_OFF_STATUS: rdata_q <= {6'h00, strb_s[1], fd};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign lnk.spi_rdata = rdata_q;

  // Half-duplex 3-bit mapping scales the low code bits into 8 dB steps
  assign rx_eff = (!fd && sel_eff[`RTGC_BIT_MAP3]) ? {rx_q[2:0], 3'h0} : rx_q;

  // Gain lookup table: fill stage 1, then 2, then 3 in 8-code slices
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_code_o <= `RTGC_RX_GAIN_RST;
      rx_stage1_o <= 3'h0;
      rx_stage2_o <= 3'h0;
      rx_stage3_o <= 3'h0;
    end else begin
      rx_code_o <= rx_eff;
      rx_stage1_o <= (rx_eff > 6'h07) ? 3'h7 : rx_eff[2:0];
      rx_stage2_o <= (rx_eff > 6'h0f) ? 3'h7 : (rx_eff > 6'h07 ? rx_eff[2:0] : 3'h0);
      rx_stage3_o <= (rx_eff > 6'h0f) ? 3'((rx_eff - 6'h10) >> 3) : 3'h0;
    end
  end

  // Transmit attenuation split: converter 0.5 dB steps, amplifier 6 dB steps
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_conv_o <= 4'h0;
      tx_amp_o <= 2'h0;
    end else begin
      tx_conv_o <= tx_q[3:0];
      tx_amp_o <= route_q[`RTGC_BIT_CONV_OUT] ? 2'h0 : tx_q[5:4];
    end
  end

  // Strobe low forwards nibbles to the filter on each sampling edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      filt_nibble_o <= 6'h00;
      filt_valid_o <= 1'b0;
    end else begin
      filt_valid_o <= fd && sample_edge && !strb_s[1];
      filt_nibble_o <= nib_s2;
    end
  end
endmodule // rtgc_dev

// *** rtgc_if.sv ***
// Pin-level link between the gain-code device end and the baseband controller end
interface rtgc_if;
  logic full_duplex;
  logic port_clock_out;
  logic [5:0] tx_nibble;
  logic transmit_nibble_phase;
  logic shared_strobe_pin;
  logic [4:0] direct_gain_low;
  logic transmit_quiet_n;
  logic [7:0] spi_addr;
  logic [7:0] spi_wdata;
  logic spi_we;
  logic spi_re;
  logic [7:0] spi_rdata;
  modport dev (input full_duplex, tx_nibble, transmit_nibble_phase, shared_strobe_pin,
    direct_gain_low, transmit_quiet_n, spi_addr, spi_wdata, spi_we, spi_re,
    output port_clock_out, spi_rdata);
  modport ctl (output full_duplex, tx_nibble, transmit_nibble_phase, shared_strobe_pin,
    direct_gain_low, transmit_quiet_n, spi_addr, spi_wdata, spi_we, spi_re,
    input port_clock_out, spi_rdata);
endinterface

// *** rtgc_pkg.sv ***
// Types of the gain-code link; only the controller end uses them
package rtgc_pkg;
  typedef logic [5:0] rtgc_code_t;
  typedef enum logic [3:0] {
    RTGC_IDLE = 4'b0001,
    RTGC_DESEL = 4'b0010,
    RTGC_PRESENT = 4'b0100,
    RTGC_SELECT = 4'b1000
  } rtgc_st_t;
endpackage

// *** rtgc_properties.sv ***
// Concurrent checks on the pin-level gain-code link between the two ends
module rtgc_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Link signals
  input wire logic full_duplex,
  input wire logic port_clock_out,
  input wire logic shared_strobe_pin,
  input wire logic transmit_quiet_n,
  input wire logic [4:0] direct_gain_low,
  input wire logic [7:0] spi_addr,
  input wire logic [7:0] spi_wdata,
  input wire logic spi_we,
  input wire logic spi_re,
  input wire logic [7:0] spi_rdata
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Addresses that answer a read; all others must read back as zero
  logic mapped;
  assign mapped = spi_addr inside {8'h09, 8'h0a, 8'h0b, 8'h0e, 8'h20, 8'h21};

  // Read data only in the cycle after a read strobe
  a_rdata_idle: assert property (!$past(spi_re) |-> spi_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero: assert property ($past(spi_re) && !$past(mapped) |-> spi_rdata == 8'h00)
    else $error("unmapped read returned data");
  a_strobes_excl: assert property (!(spi_we && spi_re))
    else $error("write and read strobes together");
  a_status_mode: assert property ($past(spi_re) && $past(spi_addr) == 8'h21 |->
    spi_rdata[0] == $past(full_duplex, 3))
    else $error("status mode bit does not follow mode pin");
  // Shared pin discipline of the controller
  a_fd_strobe_low: assert property (full_duplex |-> !shared_strobe_pin)
    else $error("shared pin high in full duplex");
  a_hd_quiet_gate: assert property (!full_duplex && !transmit_quiet_n &&
    $past(!transmit_quiet_n) |-> !shared_strobe_pin)
    else $error("shared pin high while transmitting");
  // Transmit select only once the new value already stands on the pins
  a_tx_order: assert property (spi_we && spi_addr == 8'h0b && spi_wdata[6] |->
    !spi_wdata[5] && $stable(direct_gain_low))
    else $error("transmit selected before receive deselected or value settled");
  // Port clock runs at the nibble rate, four cycles per level
  a_pclk_stable: assert property (full_duplex && $changed(port_clock_out) |=>
    $stable(port_clock_out)[*3])
    else $error("port clock level shorter than half period");
  a_pclk_toggles: assert property (full_duplex && $rose(port_clock_out) |->
    ##[1:8] $fell(port_clock_out))
    else $error("port clock stopped in full duplex");
endmodule // rtgc_properties

// *** rx_tx_gain_code_control_test.sv ***
// Self-checking bench joining both ends of the gain-code link
`include "rtgc_cfg.svh"
module rx_tx_gain_code_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_n_i, full_duplex_i, tx_quiet_n_i, rx_gain_req_i, tx_gain_req_i;
  logic reg_we_i, reg_re_i, busy_o;
  logic [5:0] rx_gain_i, tx_gain_i, rx_code_o, v, t;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [3:0] tx_conv_o;
  logic [1:0] tx_amp_o;
  logic [2:0] rx_stage1_o, rx_stage2_o, rx_stage3_o;
  logic [5:0] filt_nibble_o;
  logic filt_valid_o;
  logic [8:0] stg;
  logic [2:0] rd_pipe = 3'h0;
  logic [31:0] seed = 32'h0000bb1a;
  logic [7:0] exp_q[$];
  logic [7:0] ra[6] = '{8'h09, 8'h0a, 8'h0b, 8'h0e, 8'h21, 8'h30};
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  rtgc_if lnk();
  rtgc_dev u_rtgc_dev (.clk_i(clk_i), .rst_n_i(rst_n_i), .lnk(lnk), .rx_code_o(rx_code_o),
    .rx_stage1_o(rx_stage1_o), .rx_stage2_o(rx_stage2_o), .rx_stage3_o(rx_stage3_o),
    .tx_conv_o(tx_conv_o), .tx_amp_o(tx_amp_o), .filt_nibble_o(filt_nibble_o),
    .filt_valid_o(filt_valid_o));
  rtgc_ctl u_rtgc_ctl (.clk_i(clk_i), .rst_n_i(rst_n_i), .lnk(lnk),
    .full_duplex_i(full_duplex_i), .tx_quiet_n_i(tx_quiet_n_i), .rx_gain_i(rx_gain_i),
    .rx_gain_req_i(rx_gain_req_i), .tx_gain_i(tx_gain_i), .tx_gain_req_i(tx_gain_req_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .busy_o(busy_o));
  rtgc_properties u_rtgc_properties (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .full_duplex(lnk.full_duplex), .port_clock_out(lnk.port_clock_out),
    .shared_strobe_pin(lnk.shared_strobe_pin), .transmit_quiet_n(lnk.transmit_quiet_n),
    .direct_gain_low(lnk.direct_gain_low), .spi_addr(lnk.spi_addr),
    .spi_wdata(lnk.spi_wdata), .spi_we(lnk.spi_we), .spi_re(lnk.spi_re),
    .spi_rdata(lnk.spi_rdata));

  // Clock generator, 100 ns period
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction

  // Stage split by slices: first stage codes 0-7, second 8-15, third the rest in eights
  function automatic logic [8:0] stages(input logic [5:0] c);
    int n;
    n = c;
    return {3'(n < 8 ? n : 7), 3'(n < 8 ? 0 : (n < 16 ? n - 8 : 7)),
      3'(n < 16 ? 0 : (n - 16) / 8)};
  endfunction

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask

  // Read answer appears three edges after the strobe is taken; monitor compares it
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    exp_q.push_back(e);
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // Waits out busy, then lets pin synchronisers and port clock settle
  task automatic idle(input int n);
    repeat (2) @(posedge clk_i);
    for (int i = 0; i < 200 && busy_o !== 1'b0; i++) @(posedge clk_i);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic rxreq(input logic [5:0] g);
    @(posedge clk_i);
    rx_gain_i <= g;
    rx_gain_req_i <= 1'b1;
    @(posedge clk_i);
    rx_gain_req_i <= 1'b0;
    idle(30);
  endtask

  // Read monitor: oldest noted value against what the port returns
  always @(posedge clk_i) begin
    rd_pipe <= {rd_pipe[1:0], reg_re_i};
    if (rd_pipe[2]) chk("reg_rdata", reg_rdata_o, exp_q.pop_front());
  end

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      final_report;
    end
  end

  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    full_duplex_i = 1'b0;
    tx_quiet_n_i = 1'b1;
    rx_gain_req_i = 1'b0;
    tx_gain_req_i = 1'b0;
    rx_gain_i = 6'h00;
    tx_gain_i = 6'h00;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    idle(2);
    chk("rx_code", {2'h0, rx_code_o}, 8'h00);
    chk("tx_gain", {2'h0, tx_amp_o, tx_conv_o}, 8'h00);
    foreach (ra[i]) rd(ra[i], (ra[i] == `RTGC_OFF_SRC_SEL) ? `RTGC_SRC_SEL_HD_RST : 8'h00);
    wr(8'h0b, 8'h00);
    wr(8'h09, 8'h45);
    rd(8'h09, 8'h45);
    chk("rx_code", {2'h0, rx_code_o}, 8'h05);
    wr(8'h09, 8'h07);
    rd(8'h09, 8'h00);
    chk("rx_code", {2'h0, rx_code_o}, 8'h05);
    seed = xs(seed);
    t = seed[5:0];
    wr(8'h0a, {2'h1, t});
    wr(8'h0e, 8'h01);
    rd(8'h0a, {2'h1, t});
    chk("tx_conv", {4'h0, tx_conv_o}, {4'h0, t[3:0]});
    chk("tx_amp", {6'h0, tx_amp_o}, 8'h00);
    wr(8'h0b, 8'h20);
    seed = xs(seed);
    v = seed[5:0];
    rxreq(v);
    chk("rx_code", {2'h0, rx_code_o}, {2'h0, v});
    stg = stages(v);
    chk("rx_stage1", {5'h0, rx_stage1_o}, {5'h0, stg[8:6]});
    chk("rx_stage2", {5'h0, rx_stage2_o}, {5'h0, stg[5:3]});
    chk("rx_stage3", {5'h0, rx_stage3_o}, {5'h0, stg[2:0]});
    seed = xs(seed);
    t = seed[5:0];
    @(posedge clk_i);
    tx_gain_i <= t;
    tx_gain_req_i <= 1'b1;
    @(posedge clk_i);
    tx_gain_req_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("busy", {7'h0, busy_o}, 8'h01);
    idle(8);
    chk("tx_conv", {4'h0, tx_conv_o}, {4'h0, t[3:0]});
    chk("rx_code", {2'h0, rx_code_o}, {2'h0, v});
    wr(8'h0e, 8'h00);
    idle(2);
    chk("tx_amp", {6'h0, tx_amp_o}, {6'h0, t[5:4]});
    wr(8'h0b, 8'h22);
    seed = xs(seed);
    rxreq(seed[5:0]);
    chk("rx_code", {2'h0, rx_code_o}, {2'h0, seed[2:0], 3'h0});
    wr(8'h0b, 8'h20);
    tx_quiet_n_i <= 1'b0;
    rxreq(6'h3f);
    chk("rx_code", {2'h0, rx_code_o}, 8'h1f);
    wr(8'h0b, 8'h00);
    tx_quiet_n_i <= 1'b1;
    seed = xs(seed);
    rxreq(seed[5:0]);
    chk("rx_code", {2'h0, rx_code_o}, 8'h1f);
    full_duplex_i <= 1'b1;
    idle(8);
    rd(8'h21, 8'h01);
    // Strobe pin stays low in full duplex, so nibbles go to the filter
    for (int i = 0; i < 20 && filt_valid_o !== 1'b1; i++) @(posedge clk_i);
    chk("filt_valid", {7'h0, filt_valid_o}, 8'h01);
    chk("filt_nibble", {2'h0, filt_nibble_o}, {2'h0, seed[5:0]});
    wr(8'h0b, 8'h0c);
    seed = xs(seed);
    v = seed[5:0];
    rxreq(v);
    chk("rx_code", {2'h0, rx_code_o}, {2'h0, v});
    final_report;
  end
endmodule // rx_tx_gain_code_control_test
